// ---- idt_regs.vh ----
// Constants of the instruction decode and timing block: operation codes and cycle counts.
// Assumes inclusion by the decoder, its checker and its bench; definitions only.
`ifndef IDT_REGS_VH
`define IDT_REGS_VH
// Operation codes on op_reg
`define IDT_OP_NONE 6'h00
`define IDT_OP_MOV_IMM 6'h01
`define IDT_OP_LOAD_ACC 6'h02
`define IDT_OP_STORE_ACC 6'h03
`define IDT_OP_LOAD_SEG 6'h04
`define IDT_OP_MOVE_SIGN_EXTEND 6'h05
`define IDT_OP_MOVE_ZERO_EXTEND 6'h06
`define IDT_OP_POP_SEG 6'h07
`define IDT_OP_LOAD_POINTER_DATA_SEG 6'h08
`define IDT_OP_LOAD_POINTER_EXTRA_SEG 6'h09
`define IDT_OP_LOAD_POINTER_THIRD_SEG 6'h0A
`define IDT_OP_LOAD_POINTER_FOURTH_SEG 6'h0B
`define IDT_OP_LOAD_POINTER_STACK_SEG 6'h0C
`define IDT_OP_CLEAR_INT_ENABLE 6'h0D
`define IDT_OP_SET_INT_ENABLE 6'h0E
`define IDT_OP_CLEAR_TASK_SWITCHED 6'h0F
`define IDT_OP_SHIFT_BASE 6'h10
`define IDT_OP_DOUBLE_SHIFT_LEFT 6'h18
`define IDT_OP_DOUBLE_SHIFT_RIGHT 6'h19
`define IDT_OP_UNSIGNED_DIVIDE 6'h1A
`define IDT_OP_SIGNED_DIVIDE 6'h1B
`define IDT_OP_DECIMAL_ADJUST_MULTIPLY 6'h1C
`define IDT_OP_DECIMAL_ADJUST_DIVIDE 6'h1D
`define IDT_OP_UNSIGNED_MULTIPLY 6'h1E
`define IDT_OP_TEST 6'h1F
// Cycle counts, register form then memory form
`define IDT_CYC_MOV_IMM 6'h02
`define IDT_CYC_LOAD_ACC 6'h04
`define IDT_CYC_STORE_ACC 6'h02
`define IDT_CYC_SEG_REAL_REG 6'h02
`define IDT_CYC_SEG_REAL_MEM 6'h05
`define IDT_CYC_SEG_PROT_REG 6'h12
`define IDT_CYC_SEG_PROT_MEM 6'h13
`define IDT_CYC_EXT_REG 6'h03
`define IDT_CYC_EXT_MEM 6'h06
`define IDT_CYC_POP_SEG_REAL 6'h07
`define IDT_CYC_POP_SEG_PROT 6'h15
`define IDT_CYC_PTR_REAL 6'h07
`define IDT_CYC_PTR_PROT_SHORT 6'h16
`define IDT_CYC_PTR_PROT_LONG 6'h19
`define IDT_CYC_INT_FLAG 6'h08
`define IDT_CYC_CLEAR_TS 6'h06
`define IDT_CYC_ROT_CARRY_REG 6'h09
`define IDT_CYC_ROT_CARRY_MEM 6'h0A
`define IDT_CYC_SHIFT_REG 6'h03
`define IDT_CYC_SHIFT_MEM 6'h07
`define IDT_CYC_DIV_BYTE 6'h0E
`define IDT_CYC_DIV_WORD 6'h16
`define IDT_CYC_DIV_DWORD 6'h26
`define IDT_CYC_SIGNED_DIVIDE_BYTE 6'h13
`define IDT_CYC_SIGNED_DIVIDE_WORD 6'h1B
`define IDT_CYC_SIGNED_DIVIDE_DWORD 6'h2B
`define IDT_CYC_DIV_MEM_ADD 6'h03
`define IDT_CYC_ADJ_MUL 6'h11
`define IDT_CYC_ADJ_DIV 6'h13
`define IDT_CYC_MUL_BASE 6'h0C
`define IDT_CYC_MUL_BYTE_MAX 6'h05
`define IDT_CYC_MUL_WORD_MAX 6'h0D
`define IDT_CYC_MUL_DWORD_MAX 6'h1D
`define IDT_CYC_MUL_MEM_ADD 6'h03
`define IDT_CYC_TEST_REG 6'h02
`define IDT_CYC_TEST_MEM 6'h05
`define IDT_CYC_TEST_ACC 6'h02
`define IDT_CYC_EA_TWO_REG 6'h01
`endif

// ---- idt_decoder.v ----
// Instruction decoder and execution timer for data transfer, segment load, flag,
// arithmetic and shift groups. Assumes the prefetch queue presents whole decoded
// instruction bytes with a valid strobe and the datapath reports stall causes.
//
// Contract
// - Counting starts only once a fully fetched, decoded instruction is offered.
// - Wait states, hold requests or exceptions freeze the counter, lengthening execution.
// - Two general register address components add one cycle.
// - Register operand uses the lower count, memory operand the higher.
// - Component count reports prefixes, opcode bytes, one displacement, one immediate.
// - Opcode 1011wrrr loads register with immediate in 2 cycles.
// - Accumulator load from memory takes 4 cycles, store takes 2.
// - Segment load costs 2/5 real mode, 18/19 protected mode.
// - Sign and zero extending moves take 3 or 6 cycles.
// - One-byte segment pop costs 7 real, 21 protected.
// - Pointer loads with data or extra segment cost 7 real, 22 protected.
// - Escaped pointer loads cost 7 real; 25, 25, 22 protected.
// - Interrupt flag clear and set take 8 cycles with I/O privilege check.
// - Task switched clear takes 6 cycles, privileged in protected mode.
// - Shift field selects rotate, rotate through carry, shift or arithmetic shift.
// - Rotate through carry 9/10 cycles; other shifts and rotates 3/7.
// - Double precision shifts left and right cost 3 or 7 cycles.
// - Unsigned divide costs 14/17, 22/25, 38/41; divide faults are reported.
// - Signed divide costs 19/22, 27/30, 43/46.
// - Decimal adjust after multiply 17 cycles, before divide 19 cycles.
// - Unsigned multiply 12 plus operand dependent term; memory adds three.
// - Test updates flags from AND and writes no result; 2/5 or 2.
`timescale 1ns/1ps
`include "idt_regs.vh"
module idt_decoder #(
   parameter PREFIX_W = 2
) (
   input wire clk,
   input wire rst,
   input wire dec_valid,
   input wire [7:0] op0,
   input wire [7:0] op1,
   input wire [7:0] modrm,
   input wire [PREFIX_W-1:0] prefix_count,
   input wire prot_mode,
   input wire opsize32,
   input wire io_priv_ok,
   input wire cpl_zero,
   input wire ea_two_regs,
   input wire [31:0] mul_operand,
   input wire div_error,
   input wire exec_hold,
   output reg ready_reg,
   output reg busy_reg,
   output reg done_reg,
   output reg [5:0] op_reg,
   output reg [2:0] shift_op_field_reg,
   output reg [5:0] cycles_reg,
   output reg [3:0] comp_count_reg,
   output reg mem_operand_reg,
   output reg writes_result_reg,
   output reg fault_reg,
   output reg unknown_reg
);
   localparam ST_IDLE = 1'b0;
   localparam ST_EXEC = 1'b1;

   reg state_reg;
   reg [5:0] cnt_reg;
   reg [5:0] op_next;
   reg [5:0] cyc_next;
   reg [3:0] comp_next;
   reg mem_next;
   reg wr_next;
   reg fault_next;
   reg unk_next;
   reg uses_modrm;
   reg has_imm;
   reg has_disp;
   reg [1:0] size_sel;
   wire esc;
   wire is_mem;
   wire [2:0] sub;

   // Highest set bit of the multiplier, saturated to the size's range
   function [5:0] idt_mul_extra;
      input [31:0] val;
      input [5:0] lim;
      integer i;
      reg [5:0] top;
      begin
         top = 6'h00;
         for (i = 0; i < 32; i = i + 1) begin
            if (val[i])
               top = i[5:0];
         end
         idt_mul_extra = (top > lim) ? lim : top;
      end
   endfunction

   // Pick register or memory figure
   function [5:0] idt_pick;
      input m;
      input [5:0] r;
      input [5:0] mm;
      begin
         idt_pick = m ? mm : r;
      end
   endfunction

   // Escape byte, operand kind and sub-field are taken straight from the queue word
   assign esc = (op0 == 8'h0F);
   assign is_mem = (modrm[7:6] != 2'b11);
   assign sub = modrm[5:3];

   // Decode opcode bytes into operation, cycle figure and component count
   always @* begin
      op_next = `IDT_OP_NONE;
      cyc_next = 6'h01;
      mem_next = 1'b0;
      wr_next = 1'b1;
      fault_next = 1'b0;
      unk_next = 1'b0;
      uses_modrm = 1'b0;
      has_imm = 1'b0;
      has_disp = 1'b0;
      size_sel = op0[0] ? (opsize32 ? 2'h2 : 2'h1) : 2'h0;
      if (esc) begin
         uses_modrm = 1'b1;
         if (op1 == 8'hBE || op1 == 8'hBF) begin
            op_next = `IDT_OP_MOVE_SIGN_EXTEND;
            cyc_next = idt_pick(is_mem, `IDT_CYC_EXT_REG, `IDT_CYC_EXT_MEM);
         end else if (op1 == 8'hB6 || op1 == 8'hB7) begin
            op_next = `IDT_OP_MOVE_ZERO_EXTEND;
            cyc_next = idt_pick(is_mem, `IDT_CYC_EXT_REG, `IDT_CYC_EXT_MEM);
         end else if (op1 == 8'hB4 || op1 == 8'hB5 || op1 == 8'hB2) begin
            op_next = (op1 == 8'hB4) ? `IDT_OP_LOAD_POINTER_THIRD_SEG :
                      (op1 == 8'hB5) ? `IDT_OP_LOAD_POINTER_FOURTH_SEG :
                      `IDT_OP_LOAD_POINTER_STACK_SEG;
            cyc_next = !prot_mode ? `IDT_CYC_PTR_REAL :
                       (op1 == 8'hB2) ? `IDT_CYC_PTR_PROT_SHORT :
                       `IDT_CYC_PTR_PROT_LONG;
         end else if (op1 == 8'h06) begin
            uses_modrm = 1'b0;
            op_next = `IDT_OP_CLEAR_TASK_SWITCHED;
            cyc_next = `IDT_CYC_CLEAR_TS;
            fault_next = prot_mode && !cpl_zero;
         end else if (op1 == 8'hA4 || op1 == 8'hA5 || op1 == 8'hAC || op1 == 8'hAD) begin
            op_next = op1[3] ? `IDT_OP_DOUBLE_SHIFT_RIGHT : `IDT_OP_DOUBLE_SHIFT_LEFT;
            has_imm = !op1[0];
            cyc_next = idt_pick(is_mem, `IDT_CYC_SHIFT_REG, `IDT_CYC_SHIFT_MEM);
         end else begin
            uses_modrm = 1'b0;
            unk_next = 1'b1;
         end
      end else if (op0[7:4] == 4'hB) begin
         size_sel = op0[3] ? (opsize32 ? 2'h2 : 2'h1) : 2'h0;
         op_next = `IDT_OP_MOV_IMM;
         has_imm = 1'b1;
         cyc_next = `IDT_CYC_MOV_IMM;
      end else if (op0[7:1] == 7'h50) begin
         op_next = `IDT_OP_LOAD_ACC;
         has_disp = 1'b1;
         mem_next = 1'b1;
         cyc_next = `IDT_CYC_LOAD_ACC;
      end else if (op0[7:1] == 7'h51) begin
         op_next = `IDT_OP_STORE_ACC;
         has_disp = 1'b1;
         mem_next = 1'b1;
         cyc_next = `IDT_CYC_STORE_ACC;
      end else if (op0 == 8'h8E) begin
         uses_modrm = 1'b1;
         op_next = `IDT_OP_LOAD_SEG;
         cyc_next = prot_mode ?
                    idt_pick(is_mem, `IDT_CYC_SEG_PROT_REG, `IDT_CYC_SEG_PROT_MEM) :
                    idt_pick(is_mem, `IDT_CYC_SEG_REAL_REG, `IDT_CYC_SEG_REAL_MEM);
      end else if (op0 == 8'h07 || op0 == 8'h17 || op0 == 8'h1F) begin
         op_next = `IDT_OP_POP_SEG;
         mem_next = 1'b1;
         cyc_next = prot_mode ? `IDT_CYC_POP_SEG_PROT : `IDT_CYC_POP_SEG_REAL;
      end else if (op0 == 8'hC5 || op0 == 8'hC4) begin
         uses_modrm = 1'b1;
         op_next = op0[0] ? `IDT_OP_LOAD_POINTER_DATA_SEG : `IDT_OP_LOAD_POINTER_EXTRA_SEG;
         cyc_next = prot_mode ? `IDT_CYC_PTR_PROT_SHORT : `IDT_CYC_PTR_REAL;
      end else if (op0 == 8'hFA || op0 == 8'hFB) begin
         op_next = op0[0] ? `IDT_OP_SET_INT_ENABLE : `IDT_OP_CLEAR_INT_ENABLE;
         cyc_next = `IDT_CYC_INT_FLAG;
         fault_next = prot_mode && !io_priv_ok;
      end else if (op0[7:2] == 6'h34 || op0[7:1] == 7'h60) begin
         uses_modrm = 1'b1;
         has_imm = (op0[7:1] == 7'h60);
         op_next = `IDT_OP_SHIFT_BASE | {3'h0, sub};
         unk_next = (sub == 3'h6);
         if (sub[2:1] == 2'b01)
            cyc_next = idt_pick(is_mem, `IDT_CYC_ROT_CARRY_REG, `IDT_CYC_ROT_CARRY_MEM);
         else
            cyc_next = idt_pick(is_mem, `IDT_CYC_SHIFT_REG, `IDT_CYC_SHIFT_MEM);
      end else if (op0[7:1] == 7'h7B) begin
         uses_modrm = 1'b1;
         if (sub == 3'h0) begin
            op_next = `IDT_OP_TEST;
            has_imm = 1'b1;
            wr_next = 1'b0;
            cyc_next = idt_pick(is_mem, `IDT_CYC_TEST_REG, `IDT_CYC_TEST_MEM);
         end else if (sub == 3'h4) begin
            op_next = `IDT_OP_UNSIGNED_MULTIPLY;
            cyc_next = `IDT_CYC_MUL_BASE + idt_mul_extra(mul_operand,
                       (size_sel == 2'h0) ? `IDT_CYC_MUL_BYTE_MAX :
                       (size_sel == 2'h1) ? `IDT_CYC_MUL_WORD_MAX :
                       `IDT_CYC_MUL_DWORD_MAX)
                       + (is_mem ? `IDT_CYC_MUL_MEM_ADD : 6'h00);
         end else if (sub == 3'h6 || sub == 3'h7) begin
            op_next = sub[0] ? `IDT_OP_SIGNED_DIVIDE : `IDT_OP_UNSIGNED_DIVIDE;
            fault_next = div_error;
            if (sub[0])
               cyc_next = ((size_sel == 2'h0) ? `IDT_CYC_SIGNED_DIVIDE_BYTE :
                           (size_sel == 2'h1) ? `IDT_CYC_SIGNED_DIVIDE_WORD : `IDT_CYC_SIGNED_DIVIDE_DWORD)
                          + (is_mem ? `IDT_CYC_DIV_MEM_ADD : 6'h00);
            else
               cyc_next = ((size_sel == 2'h0) ? `IDT_CYC_DIV_BYTE :
                           (size_sel == 2'h1) ? `IDT_CYC_DIV_WORD : `IDT_CYC_DIV_DWORD)
                          + (is_mem ? `IDT_CYC_DIV_MEM_ADD : 6'h00);
         end else begin
            unk_next = 1'b1;
         end
      end else if (op0[7:1] == 7'h42) begin
         uses_modrm = 1'b1;
         op_next = `IDT_OP_TEST;
         wr_next = 1'b0;
         cyc_next = idt_pick(is_mem, `IDT_CYC_TEST_REG, `IDT_CYC_TEST_MEM);
      end else if (op0[7:1] == 7'h54) begin
         op_next = `IDT_OP_TEST;
         has_imm = 1'b1;
         wr_next = 1'b0;
         cyc_next = `IDT_CYC_TEST_ACC;
      end else if ((op0 == 8'hD4 || op0 == 8'hD5) && op1 == 8'h0A) begin
         has_imm = 1'b1; // The fixed second byte counts as one component
         op_next = op0[0] ? `IDT_OP_DECIMAL_ADJUST_DIVIDE : `IDT_OP_DECIMAL_ADJUST_MULTIPLY;
         cyc_next = op0[0] ? `IDT_CYC_ADJ_DIV : `IDT_CYC_ADJ_MUL;
      end else begin
         // Unlisted encodings still finish in one cycle so the queue never locks up
         unk_next = 1'b1;
      end
      // Mode field picks the figure; two-register addressing costs one more cycle
      if (uses_modrm) begin
         mem_next = is_mem;
         if (is_mem && ea_two_regs)
            cyc_next = cyc_next + `IDT_CYC_EA_TWO_REG;
      end
      // Prefixes, opcode bytes, modrm, one for the displacement, one for the immediate
      comp_next = {{(4-PREFIX_W){1'b0}}, prefix_count} + (esc ? 4'h2 : 4'h1)
                  + {3'h0, uses_modrm} + {3'h0, has_disp} + {3'h0, has_imm};
   end

   // Accept one instruction, then count its cycles down, freezing on stalls
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 6'h00;
         ready_reg <= 1'b0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         op_reg <= `IDT_OP_NONE;
         shift_op_field_reg <= 3'h0;
         cycles_reg <= 6'h00;
         comp_count_reg <= 4'h0;
         mem_operand_reg <= 1'b0;
         writes_result_reg <= 1'b0;
         fault_reg <= 1'b0;
         unknown_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               ready_reg <= 1'b1;
               // Every result field is latched here and stands until the next accept
               if (dec_valid && ready_reg) begin
                  state_reg <= ST_EXEC;
                  ready_reg <= 1'b0;
                  busy_reg <= 1'b1;
                  cnt_reg <= cyc_next;
                  cycles_reg <= cyc_next;
                  op_reg <= op_next;
                  shift_op_field_reg <= sub;
                  comp_count_reg <= comp_next;
                  mem_operand_reg <= mem_next;
                  writes_result_reg <= wr_next && !unk_next;
                  fault_reg <= fault_next;
                  unknown_reg <= unk_next;
               end
            end
            default: begin
               // A held edge leaves the count untouched, so stalls stretch the instruction
               if (!exec_hold) begin
                  if (cnt_reg == 6'h01) begin
                     state_reg <= ST_IDLE;
                     busy_reg <= 1'b0;
                     done_reg <= 1'b1;
                     ready_reg <= 1'b1;
                  end else begin
                     cnt_reg <= cnt_reg - 6'h01;
                  end
               end
            end
         endcase
      end
   end
endmodule // idt_decoder

// ---- idt_datapath_model.sv ----
// Far-side model of the execution datapath: raises stall cycles for the decoder.
// Assumes the bench enables stalls and that the decoder samples on the rising edge.
`timescale 1ns/1ps
module idt_datapath_model (
   input wire clk,
   input wire rst,
   input wire stall_en,
   output logic exec_hold
);
   logic [7:0] st_reg;
   // Wait states, bus holds and exceptions appear at random while enabled
   always @(negedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= 8'h5A;
         exec_hold <= 1'b0;
      end else begin
         st_reg <= {st_reg[6:0], st_reg[7] ^ st_reg[5] ^ st_reg[4] ^ st_reg[3]};
         exec_hold <= stall_en & st_reg[0] & st_reg[1];
      end
   end
endmodule // idt_datapath_model

// ---- idt_decoder_asserts.sv ----
// Checker of the decoder handshake and cycle counts, bound to every idt_decoder.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`include "idt_regs.vh"
module idt_decoder_asserts #(
   parameter PREFIX_W = 2
) (
   input wire clk,
   input wire rst,
   input wire dec_valid,
   input wire [7:0] op0,
   input wire [7:0] op1,
   input wire [7:0] modrm,
   input wire [PREFIX_W-1:0] prefix_count,
   input wire prot_mode,
   input wire opsize32,
   input wire io_priv_ok,
   input wire cpl_zero,
   input wire ea_two_regs,
   input wire [31:0] mul_operand,
   input wire div_error,
   input wire exec_hold,
   input wire ready_reg,
   input wire busy_reg,
   input wire done_reg,
   input wire [5:0] op_reg,
   input wire [2:0] shift_op_field_reg,
   input wire [5:0] cycles_reg,
   input wire [3:0] comp_count_reg,
   input wire mem_operand_reg,
   input wire writes_result_reg,
   input wire fault_reg,
   input wire unknown_reg
);
   wire acc = ready_reg && dec_valid;
   logic [7:0] e_reg;
   logic [7:0] h_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Edges and stalled edges since the last accept
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         e_reg <= 8'h00;
         h_reg <= 8'h00;
      end else if (acc) begin
         e_reg <= 8'h00;
         h_reg <= 8'h00;
      end else if (busy_reg) begin
         e_reg <= e_reg + 8'h01;
         h_reg <= h_reg + {7'h00, exec_hold};
      end
   end
   a_done_single_pulse: assert property (done_reg |=> !done_reg)
      else $error("done too long");
   a_busy_blocks_ready: assert property (busy_reg |-> !ready_reg)
      else $error("ready while busy");
   a_accept_starts_busy: assert property (acc |=> busy_reg && !ready_reg)
      else $error("accept did not start");
   a_done_frees_ready: assert property ($fell(busy_reg) |-> done_reg && ready_reg)
      else $error("busy ended without done");
   a_exact_latency: assert property (done_reg |-> e_reg == cycles_reg + h_reg)
      else $error("latency differs from count");
   a_imm_load_count: assert property (acc && op0[7:4] == 4'hB |=>
      op_reg == `IDT_OP_MOV_IMM && cycles_reg == 6'h02) else $error("immediate load");
   a_acc_move_count: assert property (acc && op0[7:2] == 6'b101000 |=>
      cycles_reg == ($past(op0[1]) ? 6'h02 : 6'h04) && mem_operand_reg)
      else $error("accumulator move");
   a_int_flag_fault: assert property (acc && op0[7:1] == 7'b1111101 |=>
      cycles_reg == 6'h08 && fault_reg == ($past(prot_mode) && !$past(io_priv_ok)))
      else $error("interrupt flag op");
   a_test_no_write: assert property (acc && op0[7:1] == 7'b1000010 |=>
      !writes_result_reg && cycles_reg == ($past(modrm[7:6]) == 2'b11 ? 6'h02 :
      6'h05 + $past(ea_two_regs))) else $error("test op");
   a_comp_one_byte: assert property (acc && op0 == 8'hFA |=>
      comp_count_reg == $past(prefix_count) + 1) else $error("component count");
   c_divide: cover property (acc && op0 == 8'hF7);
   c_stalled_done: cover property (done_reg && h_reg != 8'h00);
   c_fault_done: cover property (done_reg && fault_reg);
endmodule // idt_decoder_asserts
bind idt_decoder idt_decoder_asserts #(.PREFIX_W(PREFIX_W)) u_chk (.clk(clk), .rst(rst),
   .dec_valid(dec_valid), .op0(op0), .op1(op1), .modrm(modrm), .prefix_count(prefix_count),
   .prot_mode(prot_mode), .opsize32(opsize32), .io_priv_ok(io_priv_ok), .cpl_zero(cpl_zero),
   .ea_two_regs(ea_two_regs), .mul_operand(mul_operand), .div_error(div_error),
   .exec_hold(exec_hold), .ready_reg(ready_reg), .busy_reg(busy_reg), .done_reg(done_reg),
   .op_reg(op_reg), .shift_op_field_reg(shift_op_field_reg), .cycles_reg(cycles_reg),
   .comp_count_reg(comp_count_reg), .mem_operand_reg(mem_operand_reg),
   .writes_result_reg(writes_result_reg), .fault_reg(fault_reg), .unknown_reg(unknown_reg));

// ---- instruction_decode_timing_tb.sv ----
// Self-checking bench for idt_decoder with a timing model of the rules.
// Assumes idt_datapath_model as the stalling far side and the bound checker.
`timescale 1ns/1ps
`include "idt_regs.vh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin failures++; \
   $display("[ERR] %s expected %0d seen %0d", nm, ex, got); end end
module instruction_decode_timing_tb;
   logic clk, rst, dec_valid, prot_mode, opsize32, io_priv_ok, cpl_zero, ea_two_regs;
   logic div_error, stall_en;
   logic [7:0] op0, op1, modrm;
   logic [1:0] prefix_count;
   logic [31:0] mul_operand;
   wire exec_hold, ready_reg, busy_reg, done_reg, mem_operand_reg, writes_result_reg;
   wire fault_reg, unknown_reg;
   wire [5:0] op_reg, cycles_reg;
   wire [2:0] shift_op_field_reg;
   wire [3:0] comp_count_reg;
   int failures = 0;
   int cmp_count = 0;
   int ef, eu, em, ew, ec, eo;
   logic [15:0] seed = 16'h000F;
   logic [19:0] tbl[$] = '{20'hB8000, 20'hA1000, 20'hA3000, 20'h8E003, 20'h0FBE0,
      20'h0FB60, 20'h1F000, 20'h07000, 20'h17000, 20'hC5000, 20'hC4000, 20'h0FB40,
      20'h0FB50, 20'h0FB20, 20'hFA000, 20'hFB000, 20'h0F060, 20'hC1002, 20'hD3007,
      20'h0FA40, 20'h0FAC0, 20'hF7006, 20'hF6006, 20'hF7007, 20'hF6007, 20'hD40A0,
      20'hD50A0, 20'hF7004, 20'hF6004, 20'h85000, 20'hF7000, 20'hF7002,
      20'hA8000};
   idt_decoder dut (.clk(clk), .rst(rst), .dec_valid(dec_valid), .op0(op0), .op1(op1),
      .modrm(modrm), .prefix_count(prefix_count), .prot_mode(prot_mode), .opsize32(opsize32),
      .io_priv_ok(io_priv_ok), .cpl_zero(cpl_zero), .ea_two_regs(ea_two_regs),
      .mul_operand(mul_operand), .div_error(div_error), .exec_hold(exec_hold),
      .ready_reg(ready_reg), .busy_reg(busy_reg), .done_reg(done_reg), .op_reg(op_reg),
      .shift_op_field_reg(shift_op_field_reg), .cycles_reg(cycles_reg),
      .comp_count_reg(comp_count_reg), .mem_operand_reg(mem_operand_reg),
      .writes_result_reg(writes_result_reg), .fault_reg(fault_reg), .unknown_reg(unknown_reg));
   idt_datapath_model u_dp (.clk(clk), .rst(rst), .stall_en(stall_en), .exec_hold(exec_hold));
   // Clock of 50 ns period
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   function automatic [15:0] lfsr_next(input [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Listed count of one instruction; also sets every expected field of the result except the shift field
   function automatic int model(input [7:0] a, input [7:0] b, input [7:0] m, input [31:0] mu);
      int r, md, pen, t, hb;
      int dv[3] = '{14, 22, 38};
      int iv[3] = '{19, 27, 43};
      int ml[3] = '{5, 13, 29};
      r = (m[7:6] == 2'b11);
      md = !r;
      pen = (!r && ea_two_regs);
      t = a[0] ? (opsize32 ? 2 : 1) : 0;
      hb = 0;
      ef = 0;
      eu = 0;
      em = 0;
      ew = 1;
      eo = `IDT_OP_NONE;
      ec = prefix_count + 1;
      for (int i = 0; i < 32; i++) if (mu[i]) hb = i;
      case (a)
         8'hA0, 8'hA1, 8'hA2, 8'hA3: begin
            eo = a[1] ? `IDT_OP_STORE_ACC : `IDT_OP_LOAD_ACC;
            em = 1;
            ec++;
            return a[1] ? 2 : 4;
         end
         8'h07, 8'h17, 8'h1F: begin
            eo = `IDT_OP_POP_SEG;
            em = 1;
            return prot_mode ? 21 : 7;
         end
         8'hFA, 8'hFB: begin
            eo = a[0] ? `IDT_OP_SET_INT_ENABLE : `IDT_OP_CLEAR_INT_ENABLE;
            ef = prot_mode && !io_priv_ok;
            return 8;
         end
         8'hD4, 8'hD5: begin
            eo = a[0] ? `IDT_OP_DECIMAL_ADJUST_DIVIDE : `IDT_OP_DECIMAL_ADJUST_MULTIPLY;
            ec++;
            return a[0] ? 19 : 17;
         end
         8'h8E: begin
            eo = `IDT_OP_LOAD_SEG;
            em = md;
            ec++;
            return (prot_mode ? (r ? 18 : 19) : (r ? 2 : 5)) + pen;
         end
         8'hC4, 8'hC5: begin
            eo = a[0] ? `IDT_OP_LOAD_POINTER_DATA_SEG : `IDT_OP_LOAD_POINTER_EXTRA_SEG;
            em = md;
            ec++;
            return (prot_mode ? 22 : 7) + pen;
         end
         8'h84, 8'h85, 8'hA8, 8'hA9: begin
            eo = `IDT_OP_TEST;
            ew = 0;
            ec++;
            if (a[7:4] == 4'hA) return 2;
            em = md;
            return (r ? 2 : 5) + pen;
         end
         8'hC0, 8'hC1, 8'hD0, 8'hD1, 8'hD2, 8'hD3: begin
            eo = `IDT_OP_SHIFT_BASE + m[5:3];
            eu = (m[5:3] == 3'b110);
            ew = !eu;
            em = md;
            ec += a[4] ? 1 : 2;
            return (m[5:4] == 2'b01 ? (r ? 9 : 10) : (r ? 3 : 7)) + pen;
         end
         8'hF6, 8'hF7: begin
            ef = m[5:4] == 2'b11 && div_error;
            em = md;
            ec++;
            case (m[5:3])
               3'b000: begin
                  eo = `IDT_OP_TEST;
                  ew = 0;
                  ec++;
                  return (r ? 2 : 5) + pen;
               end
               3'b100: begin
                  eo = `IDT_OP_UNSIGNED_MULTIPLY;
                  return 12 + (hb < ml[t] ? hb : ml[t]) + (r ? 0 : 3) + pen;
               end
               3'b110: begin
                  eo = `IDT_OP_UNSIGNED_DIVIDE;
                  return dv[t] + (r ? 0 : 3) + pen;
               end
               3'b111: begin
                  eo = `IDT_OP_SIGNED_DIVIDE;
                  return iv[t] + (r ? 0 : 3) + pen;
               end
               default: begin
                  eu = 1;
                  ew = 0;
                  return 1 + pen;
               end
            endcase
         end
         8'h0F: begin
            ec++;
            case (b)
               8'hBE, 8'hBF, 8'hB6, 8'hB7: begin
                  eo = b[3] ? `IDT_OP_MOVE_SIGN_EXTEND : `IDT_OP_MOVE_ZERO_EXTEND;
                  em = md;
                  ec++;
                  return (r ? 3 : 6) + pen;
               end
               8'hB4, 8'hB5, 8'hB2: begin
                  eo = !b[2] ? `IDT_OP_LOAD_POINTER_STACK_SEG :
                     b[0] ? `IDT_OP_LOAD_POINTER_FOURTH_SEG : `IDT_OP_LOAD_POINTER_THIRD_SEG;
                  em = md;
                  ec++;
                  return (prot_mode ? (b[2] ? 25 : 22) : 7) + pen;
               end
               8'hA4, 8'hA5, 8'hAC, 8'hAD: begin
                  eo = b[3] ? `IDT_OP_DOUBLE_SHIFT_RIGHT : `IDT_OP_DOUBLE_SHIFT_LEFT;
                  em = md;
                  ec += b[0] ? 1 : 2;
                  return (r ? 3 : 7) + pen;
               end
               8'h06: begin
                  eo = `IDT_OP_CLEAR_TASK_SWITCHED;
                  ef = prot_mode && !cpl_zero;
                  return 6;
               end
               default: begin
                  eu = 1;
                  ew = 0;
                  return 1;
               end
            endcase
         end
         default: begin
            eu = (a[7:4] != 4'hB);
            ew = !eu;
            if (eu) return 1;
            eo = `IDT_OP_MOV_IMM;
            ec++;
            return 2;
         end
      endcase
      return 1;
   endfunction
   // Offers one instruction, times it and compares with the model
   task automatic run_one(input [19:0] w, input [1:0] md);
      int n, h, ex, k;
      logic hv;
      n = 0;
      h = 0;
      k = 0;
      while (ready_reg !== 1'b1 && k < 100) begin
         @(negedge clk);
         k++;
      end
      seed = lfsr_next(seed);
      {op0, op1} = w[19:4];
      modrm = {md, w[2:0], seed[2:0]};
      {div_error, ea_two_regs, cpl_zero, io_priv_ok, opsize32, prot_mode} = seed[8:3];
      prefix_count = seed[10:9];
      mul_operand = 32'h1 << seed[15:11];
      ex = model(op0, op1, modrm, mul_operand);
      dec_valid = 1'b1; // Whole decoded instruction offered
      @(negedge clk);
      dec_valid = 1'b0;
      while (done_reg !== 1'b1 && n < 200) begin
         @(posedge clk);
         hv = exec_hold;
         @(negedge clk);
         n++;
         if (done_reg !== 1'b1) h += hv;
      end
      `CHK("latency", ex + h, n)
      `CHK("cycles", ex, cycles_reg)
      `CHK("fault", ef, fault_reg)
      `CHK("unknown", eu, unknown_reg)
      `CHK("op", eo, op_reg)
      `CHK("field", modrm[5:3], shift_op_field_reg)
      `CHK("components", ec, comp_count_reg)
      `CHK("memory", em, mem_operand_reg)
      `CHK("writes", ew, writes_result_reg)
   endtask
   task automatic finish_test;
      $display("Comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Main sequence: every entry in all four operand modes, without and with stalls
   initial begin
      rst = 1'b1;
      {dec_valid, op0, op1, modrm, prefix_count, prot_mode, opsize32} = '0;
      {io_priv_ok, cpl_zero, ea_two_regs, mul_operand, div_error, stall_en} = '0;
      for (int s = 0; s < 8; s++) tbl.push_back({8'hD1, 8'h00, 1'b0, 3'(s)});
      repeat (4) @(negedge clk);
      `CHK("reset ready", 0, ready_reg)
      `CHK("reset busy", 0, busy_reg)
      rst = 1'b0;
      for (int p = 0; p < 2; p++) begin
         stall_en = p[0];
         foreach (tbl[i]) for (int v = 0; v < 4; v++) run_one(tbl[i], 2'(v) - 2'd1);
      end
      finish_test;
   end
   // Watchdog against a hang
   initial begin
      #2000000;
      failures++;
      finish_test;
   end
endmodule // instruction_decode_timing_tb
